//--- pscc_consts.vh
// Constants for the supply and charger control block: register offsets,
// field positions, reset values and timing counts.
// Assumes an 8-bit special-function register port from the MCU, 40 MHz clock.
//
// Operation
// - I/O supply level field, bits 6:4
// - Core coarse level field, bits 3:1
// - Bit 0 adds one fine core step
// - Source-present sets after debounce interval
// - Source removal reported after same debounce
// - Charger enable drives current request immediately
// - Trickle below 3.0 V requests one tenth
// - Four-bit charge current code, reset 0101
// - Over-temperature flag follows sensed comparator
// - Phase reads 00 unless bit 7 set
// - Current band field reports measured band
// - Charging status rises after one second
// - Charging status falls at once below 7.5%
// - Test bit reads set when no current flows, unfiltered
// - Over-temperature threshold select, reset 10
// - Monitor rate select bit, reset 1
// - Main supply enable bit, reset 1
// - Always-on writes land after 3+4 clocks
// - Long-press flag reported from key timer
`ifndef PSCC_CONSTS_VH
`define PSCC_CONSTS_VH

// =====================================================
// Register offsets
`define PSCC_A_SUPPLY_LEVEL   8'h90
`define PSCC_A_IO_CURLIM      8'h92
`define PSCC_A_CHG_CTRL       8'h94
`define PSCC_A_CHARGER_DETECT_STATUS        8'h95
`define PSCC_A_CHG_TEMP       8'h97
`define PSCC_A_MON_ADC        8'h9B
`define PSCC_A_BAT_READ       8'h9C
`define PSCC_A_TEMP_READ      8'h9D
`define PSCC_A_WIRE_READ      8'h9E
`define PSCC_A_PIN_SHARED     8'hA4
`define PSCC_A_SYS_VOLT       8'hA5
`define PSCC_A_AON_CTRL       8'hA7
`define PSCC_A_KEY_STATUS     8'hA9

// =====================================================
// Reset values
`define PSCC_R_SUPPLY_LEVEL   8'h58
`define PSCC_R_IO_CURLIM      8'h00
`define PSCC_R_CHG_CTRL       8'h05
`define PSCC_R_CHG_TEMP       8'h6F
`define PSCC_R_MON_ADC        8'hC0
`define PSCC_R_PIN_SHARED     8'h40
`define PSCC_R_SYS_VOLT       8'h00
`define PSCC_R_AON_CTRL       8'h67
`define PSCC_R_KEY_STATUS     8'h20

// =====================================================
// Field positions
`define PSCC_F_IO_LVL_HI      6
`define PSCC_F_IO_LVL_LO      4
`define PSCC_F_CORE_LVL_HI    3
`define PSCC_F_CORE_LVL_LO    1
`define PSCC_F_CORE_FINE      0
`define PSCC_F_SRC_PRESENT    7
`define PSCC_F_CHG_EN         5
`define PSCC_F_TRICKLE_EN     4
`define PSCC_F_CUR_HI         3
`define PSCC_F_CUR_LO         0
`define PSCC_F_OVERHEAT       7
`define PSCC_F_CHG_TEST       6
`define PSCC_F_THR_HI         5
`define PSCC_F_THR_LO         4
`define PSCC_F_RATE_SEL       7
`define PSCC_F_MAIN_EN        0
`define PSCC_F_LONG_PRESS     6
`define PSCC_F_SHORT_PRESS    7

// =====================================================
// Timing: figures in their own units, counts derived at 40 MHz
`define PSCC_CLK_HZ           40000000
`define PSCC_DEB_LONG_MS      16
`define PSCC_DEB_SHORT_US     41
`define PSCC_CHG_QUAL_S       1
`define PSCC_DEB_LONG_CYC     ((`PSCC_DEB_LONG_MS * `PSCC_CLK_HZ) / 1000)
`define PSCC_DEB_SHORT_CYC    ((`PSCC_DEB_SHORT_US * (`PSCC_CLK_HZ / 1000)) / 1000)
`define PSCC_CHG_QUAL_CYC     (`PSCC_CHG_QUAL_S * `PSCC_CLK_HZ)
`define PSCC_AON_MCU_CYC      3
`define PSCC_AON_LF_CYC       4

`endif

//--- pscc_sync.v
// Two-flop synchroniser for a group of level signals from the analog side.
// Assumes inputs are quasi-static levels; no pulse is guaranteed to pass.
`timescale 1ns/1ps
module pscc_sync #(
  parameter W = 8
) (
  input  wire         clk_i,   // MCU clock
  input  wire         srst_i,  // Synchronous reset
  input  wire [W-1:0] d_i,     // Asynchronous levels
  output reg  [W-1:0] q_o      // Synchronised levels
);
  // =====================================================
  // Stages
  reg [W-1:0] meta_q;  // First stage, read only by second stage

  // Two flops in series
  always @(posedge clk_i) begin
    if (srst_i) begin
      meta_q <= {W{1'b0}};
      q_o    <= {W{1'b0}};
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end
endmodule

//--- pscc_top.v
// Supply and charger control: special-function registers of the power unit.
// Assumes an 8-bit register port from the MCU, analog levels arriving
// asynchronously, and a free-running low-frequency clock given as a level.
`timescale 1ns/1ps
`include "pscc_consts.vh"
module pscc_top #(
  parameter [31:0] DEB_LONG_CYC  = `PSCC_DEB_LONG_CYC,   // Source debounce, long
  parameter [31:0] DEB_SHORT_CYC = `PSCC_DEB_SHORT_CYC,  // Source debounce, short
  parameter [31:0] CHG_QUAL_CYC  = `PSCC_CHG_QUAL_CYC    // Charging qualify time
) (
  input  wire       clk_i,              // MCU clock, 40 MHz
  input  wire       srst_i,             // Synchronous reset, active high
  input  wire       reg_sel_i,          // Register access strobe, bank selected
  input  wire       reg_wr_i,           // 1 write, 0 read
  input  wire [7:0] reg_addr_i,         // Register offset
  input  wire [7:0] reg_wdata_i,        // Write data
  output reg  [7:0] reg_rdata_o,        // Read data, one cycle after strobe
  input  wire       deb_short_i,        // Selects short source debounce
  input  wire       lf_clk_i,           // Low-frequency clock, sampled
  input  wire       src_present_i,      // Comparator: source above thresholds
  input  wire       src_absent_i,       // Comparator: source below thresholds
  input  wire       bat_low_i,          // Comparator: battery below 3.0 V
  input  wire       overheat_i,         // Comparator: over temperature
  input  wire       cur_tenth_i,        // Current at or above one tenth
  input  wire       cur_low_i,          // Current at or below 7.5 %
  input  wire       cur_flow_i,         // Any charge current flowing
  input  wire [1:0] phase_i,            // Charging phase from charger
  input  wire [2:0] band_i,             // Measured current band
  input  wire       long_press_i,       // Key held longer than set time
  input  wire [6:0] bat_level_i,        // Battery reading
  input  wire [6:0] temp_level_i,       // Temperature reading
  input  wire [5:0] wire_level_i,       // Wire-remote reading
  output reg  [2:0] io_supply_level_o,  // I/O supply code
  output reg  [2:0] core_supply_level_o,// Core coarse code
  output reg        core_supply_fine_o, // Core fine step enable
  output reg        charge_enable_o,    // Charge circuit enable
  output reg  [3:0] charge_current_o,   // Requested current code
  output reg        charge_tenth_o,     // Request one tenth of code
  output reg  [1:0] overheat_threshold_sel_o, // Temperature threshold
  output reg        monitor_rate_sel_o, // Monitor ADC rate
  output reg        main_supply_enable_o// Main supply enable
);
  // =====================================================
  // Synchronised analog inputs
  wire [33:0] sync_w;  // All status levels after two flops
  pscc_sync #(.W(34)) u_sync (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .d_i    ({lf_clk_i, src_present_i, src_absent_i, bat_low_i, overheat_i,
              cur_tenth_i, cur_low_i, cur_flow_i, phase_i, band_i, long_press_i,
              bat_level_i, temp_level_i, wire_level_i}),
    .q_o    (sync_w)
  );
  wire       lf_s       = sync_w[33];     // Low-frequency clock level
  wire       present_s  = sync_w[32];     // Source present condition
  wire       absent_s   = sync_w[31];     // Source absent condition
  wire       bat_low_s  = sync_w[30];     // Battery below 3.0 V
  wire       hot_s      = sync_w[29];     // Over temperature
  wire       tenth_s    = sync_w[28];     // Current at or above a tenth
  wire       cur_low_s  = sync_w[27];     // Current at or below 7.5 %
  wire       flow_s     = sync_w[26];     // Current flowing
  wire [1:0] phase_s    = sync_w[25:24];  // Phase
  wire [2:0] band_s     = sync_w[23:21];  // Band
  wire       long_s     = sync_w[20];     // Long press
  wire [6:0] bat_s      = sync_w[19:13];  // Battery reading
  wire [6:0] temp_s     = sync_w[12:6];   // Temperature reading
  wire [5:0] wire_s     = sync_w[5:0];    // Wire reading

  // =====================================================
  // Software-writable registers and internal state
  reg [7:0] level_q;     // Supply level select
  reg [7:0] curlim_q;    // I/O supply current limit
  reg [7:0] chgctl_q;    // Charger control, writable bits
  reg [7:0] tlim_q;      // Charge temperature limit
  reg [7:0] adc_q;       // Monitor ADC control
  reg [7:0] pinsh_q;     // Pin shared supply control
  reg [7:0] sysv_q;      // System voltage detect
  reg [7:0] aon_q;       // Always-on control, value in effect
  reg [7:0] aon_pend_q;  // Always-on value waiting to land
  reg [4:0] keyres_q;    // Key status reserved bits 7 and 5:3
  reg       src_q;       // Debounced source present
  reg [31:0] deb_cnt_q;  // Source debounce counter
  reg       chg_stat_q;  // Charging status
  reg [31:0] qual_cnt_q; // Charging qualify counter
  reg [1:0] aon_mcu_q;   // MCU cycles since always-on write
  reg [2:0] aon_lf_q;    // Low-frequency edges since write
  reg       aon_busy_q;  // Always-on write in flight
  reg       lf_prev_q;   // Previous low-frequency level

  wire wr_w = reg_sel_i & reg_wr_i;   // Register write this cycle
  wire rd_w = reg_sel_i & ~reg_wr_i;  // Register read this cycle

  // Write strobe per offset
  function wr_hit;
    input [7:0] a;
    begin
      wr_hit = wr_w & (reg_addr_i == a);
    end
  endfunction

  // =====================================================
  // Register writes; reserved bits simply store
  always @(posedge clk_i) begin
    if (srst_i) begin
      level_q  <= `PSCC_R_SUPPLY_LEVEL;  // 101, 100, 0
      curlim_q <= `PSCC_R_IO_CURLIM;
      chgctl_q <= `PSCC_R_CHG_CTRL;      // Current code 0101, enable 0
      tlim_q   <= `PSCC_R_CHG_TEMP;      // Threshold 10
      adc_q    <= `PSCC_R_MON_ADC;       // Rate select 1
      pinsh_q  <= `PSCC_R_PIN_SHARED;
      sysv_q   <= `PSCC_R_SYS_VOLT;
      keyres_q <= 5'h08;                 // Reserved bits 5:3 reset to 100
    end else begin
      if (wr_hit(`PSCC_A_SUPPLY_LEVEL)) level_q  <= reg_wdata_i;
      if (wr_hit(`PSCC_A_IO_CURLIM))    curlim_q <= reg_wdata_i;
      if (wr_hit(`PSCC_A_CHG_CTRL))     chgctl_q <= {1'b0, reg_wdata_i[6:0]};
      if (wr_hit(`PSCC_A_CHG_TEMP))     tlim_q   <= reg_wdata_i;
      if (wr_hit(`PSCC_A_MON_ADC))      adc_q    <= reg_wdata_i;
      if (wr_hit(`PSCC_A_PIN_SHARED))   pinsh_q  <= reg_wdata_i;
      if (wr_hit(`PSCC_A_SYS_VOLT))     sysv_q   <= reg_wdata_i;
      if (wr_hit(`PSCC_A_KEY_STATUS))
        keyres_q <= {reg_wdata_i[7], reg_wdata_i[5:3], 1'b0};
    end
  end

  // =====================================================
  // Always-on write: lands after 3 MCU clocks and 4 low-frequency edges
  always @(posedge clk_i) begin
    if (srst_i) begin
      aon_q      <= `PSCC_R_AON_CTRL;    // Main enable resets to 1
      aon_pend_q <= `PSCC_R_AON_CTRL;
      aon_busy_q <= 1'b0;
      aon_mcu_q  <= 2'h0;
      aon_lf_q   <= 3'h0;
      lf_prev_q  <= 1'b0;
    end else begin
      lf_prev_q <= lf_s;
      if (wr_hit(`PSCC_A_AON_CTRL)) begin
        // New write restarts the wait; the older value is superseded
        aon_pend_q <= reg_wdata_i;
        aon_busy_q <= 1'b1;
        aon_mcu_q  <= 2'h0;
        aon_lf_q   <= 3'h0;
      end else if (aon_busy_q) begin
        if (aon_mcu_q != 2'd`PSCC_AON_MCU_CYC)
          aon_mcu_q <= aon_mcu_q + 2'h1;
        else if (aon_lf_q != 3'd`PSCC_AON_LF_CYC) begin
          if (lf_s & ~lf_prev_q)
            aon_lf_q <= aon_lf_q + 3'h1;
        end else begin
          aon_q      <= aon_pend_q;  // Value takes effect and reads back
          aon_busy_q <= 1'b0;
        end
      end
    end
  end

  // =====================================================
  // Source-present debounce: the opposite condition must persist
  wire [31:0] deb_len_w = deb_short_i ? DEB_SHORT_CYC : DEB_LONG_CYC;
  wire        src_flip_w = src_q ? absent_s : present_s;
  always @(posedge clk_i) begin
    if (srst_i) begin
      src_q     <= 1'b0;
      deb_cnt_q <= 32'h0;
    end else if (!src_flip_w) begin
      deb_cnt_q <= 32'h0;                // Condition broke, restart
    end else if (deb_cnt_q >= deb_len_w - 32'h1) begin
      src_q     <= ~src_q;               // Attach or removal
      deb_cnt_q <= 32'h0;
    end else begin
      deb_cnt_q <= deb_cnt_q + 32'h1;
    end
  end

  // =====================================================
  // Charging status: slow rise, fast fall
  always @(posedge clk_i) begin
    if (srst_i) begin
      chg_stat_q <= 1'b0;
      qual_cnt_q <= 32'h0;
    end else if (chg_stat_q) begin
      qual_cnt_q <= 32'h0;
      if (cur_low_s)
        chg_stat_q <= 1'b0;              // Drop without delay
    end else if (!tenth_s) begin
      qual_cnt_q <= 32'h0;               // Must be continuous
    end else if (qual_cnt_q >= CHG_QUAL_CYC - 32'h1) begin
      chg_stat_q <= 1'b1;                // Held for one second
      qual_cnt_q <= 32'h0;
    end else begin
      qual_cnt_q <= qual_cnt_q + 32'h1;
    end
  end

  // =====================================================
  // Status words
  wire [1:0] phase_rd_w = hot_s ? phase_s : 2'b00;  // Masked phase
  wire [7:0] det_w = {hot_s,                        // Over-temperature
                      ~flow_s,                      // Unfiltered test bit
                      phase_rd_w,
                      band_s,                       // Current band
                      chg_stat_q};
  wire [7:0] ctl_rd_w = {src_q, chgctl_q[6:0]};

  // =====================================================
  // Read mux, registered
  always @(posedge clk_i) begin
    if (srst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (rd_w) begin
      case (reg_addr_i)
        `PSCC_A_SUPPLY_LEVEL: reg_rdata_o <= level_q;
        `PSCC_A_IO_CURLIM:    reg_rdata_o <= curlim_q;
        `PSCC_A_CHG_CTRL:     reg_rdata_o <= ctl_rd_w;
        `PSCC_A_CHARGER_DETECT_STATUS:      reg_rdata_o <= det_w;
        `PSCC_A_CHG_TEMP:     reg_rdata_o <= tlim_q;
        `PSCC_A_MON_ADC:      reg_rdata_o <= adc_q;
        `PSCC_A_BAT_READ:     reg_rdata_o <= {1'b0, bat_s};
        `PSCC_A_TEMP_READ:    reg_rdata_o <= {1'b0, temp_s};
        `PSCC_A_WIRE_READ:    reg_rdata_o <= {2'b00, wire_s};
        `PSCC_A_PIN_SHARED:   reg_rdata_o <= pinsh_q;
        `PSCC_A_SYS_VOLT:     reg_rdata_o <= sysv_q;
        `PSCC_A_AON_CTRL:     reg_rdata_o <= aon_q;
        `PSCC_A_KEY_STATUS:   reg_rdata_o <= {keyres_q[4], long_s, keyres_q[3:1], 3'b000};
        default:              reg_rdata_o <= 8'h00;  // Unmapped reads zero
      endcase
    end
  end

  // =====================================================
  // Outputs to the analog side, all from flops
  always @(posedge clk_i) begin
    if (srst_i) begin
      io_supply_level_o        <= 3'b101;
      core_supply_level_o      <= 3'b100;
      core_supply_fine_o       <= 1'b0;
      charge_enable_o          <= 1'b0;
      charge_current_o         <= 4'h5;
      charge_tenth_o           <= 1'b0;
      overheat_threshold_sel_o <= 2'b10;
      monitor_rate_sel_o       <= 1'b1;
      main_supply_enable_o     <= 1'b1;
    end else begin
      io_supply_level_o   <= level_q[`PSCC_F_IO_LVL_HI:`PSCC_F_IO_LVL_LO];
      core_supply_level_o <= level_q[`PSCC_F_CORE_LVL_HI:`PSCC_F_CORE_LVL_LO];
      core_supply_fine_o  <= level_q[`PSCC_F_CORE_FINE];
      // Enable passes with no qualifying wait; software set up USB domain
      charge_enable_o     <= chgctl_q[`PSCC_F_CHG_EN];
      charge_current_o    <= chgctl_q[`PSCC_F_CUR_HI:`PSCC_F_CUR_LO];
      charge_tenth_o      <= chgctl_q[`PSCC_F_TRICKLE_EN] & bat_low_s;
      overheat_threshold_sel_o <= tlim_q[`PSCC_F_THR_HI:`PSCC_F_THR_LO];
      monitor_rate_sel_o  <= adc_q[`PSCC_F_RATE_SEL];
      main_supply_enable_o <= aon_q[`PSCC_F_MAIN_EN];
    end
  end
endmodule

//--- pscc_checker.sv
// Checker for the supply and charger control block: reset values, read answers
// and the timing from register writes to the analog control outputs.
// Assumes it is bound into pscc_top and watches that module's ports only.
`timescale 1ns/1ps
module pscc_checker (
  input wire       clk_i,
  input wire       srst_i,
  input wire       reg_sel_i,
  input wire       reg_wr_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire [7:0] reg_rdata_o,
  input wire       bat_low_i,
  input wire [2:0] io_supply_level_o,
  input wire [2:0] core_supply_level_o,
  input wire       core_supply_fine_o,
  input wire       charge_enable_o,
  input wire [3:0] charge_current_o,
  input wire       charge_tenth_o,
  input wire [1:0] overheat_threshold_sel_o,
  input wire       monitor_rate_sel_o,
  input wire       main_supply_enable_o
);
  // ==========================================================
  // Clocking and helpers
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  wire wr_x = reg_sel_i & reg_wr_i;   // Write taken at this edge
  wire rd_x = reg_sel_i & ~reg_wr_i;  // Read taken at this edge

  // ==========================================================
  // Assertions: reset values, unmapped reads, outputs two edges after a write, always-on delay, tenth request
  a_reset_values: assert property ($fell(srst_i) |-> io_supply_level_o == 3'h5
    && core_supply_level_o == 3'h4 && !core_supply_fine_o && !charge_enable_o
    && charge_current_o == 4'h5 && overheat_threshold_sel_o == 2'h2
    && monitor_rate_sel_o && main_supply_enable_o) else $error("outputs off reset values");
  a_unmapped_read: assert property (rd_x && reg_addr_i == 8'h80 |=>
    reg_rdata_o == 8'h00) else $error("unmapped read not zero");
  a_io_level: assert property (wr_x && reg_addr_i == 8'h90 |-> ##2
    io_supply_level_o == $past(reg_wdata_i[6:4], 2)) else $error("io level not applied");
  a_core_level: assert property (wr_x && reg_addr_i == 8'h90 |-> ##2
    {core_supply_level_o, core_supply_fine_o} == $past(reg_wdata_i[3:0], 2))
    else $error("core level not applied");
  a_charge_ctrl: assert property (wr_x && reg_addr_i == 8'h94 |-> ##2
    {charge_enable_o, charge_current_o} == {$past(reg_wdata_i[5], 2), $past(reg_wdata_i[3:0], 2)})
    else $error("charge control not applied");
  a_thr_select: assert property (wr_x && reg_addr_i == 8'h97 |-> ##2
    overheat_threshold_sel_o == $past(reg_wdata_i[5:4], 2)) else $error("threshold not applied");
  a_rate_select: assert property (wr_x && reg_addr_i == 8'h9B |-> ##2
    monitor_rate_sel_o == $past(reg_wdata_i[7], 2)) else $error("rate not applied");
  a_aon_delay: assert property (wr_x && reg_addr_i == 8'hA7 |=> ##1
    $stable(main_supply_enable_o) [*3]) else $error("always-on write landed early");
  a_tenth_off: assert property (!bat_low_i [*4] |-> !charge_tenth_o)
    else $error("tenth request without low battery");

  // ==========================================================
  // Cover points for the main scenarios
  c_charge_on: cover property (wr_x && reg_addr_i == 8'h94 && reg_wdata_i[5]);
  c_tenth_up: cover property ($rose(charge_tenth_o));
  c_main_off: cover property ($fell(main_supply_enable_o));
endmodule

bind pscc_top pscc_checker u_chk (.clk_i(clk_i), .srst_i(srst_i), .reg_sel_i(reg_sel_i),
  .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o), .bat_low_i(bat_low_i), .io_supply_level_o(io_supply_level_o),
  .core_supply_level_o(core_supply_level_o), .core_supply_fine_o(core_supply_fine_o),
  .charge_enable_o(charge_enable_o), .charge_current_o(charge_current_o),
  .charge_tenth_o(charge_tenth_o), .overheat_threshold_sel_o(overheat_threshold_sel_o),
  .monitor_rate_sel_o(monitor_rate_sel_o), .main_supply_enable_o(main_supply_enable_o));

//--- pscc_analog_model.sv
// Behavioural model of the analog side: source and current comparators, charger
// phase and band, power key and a free-running slow clock.
// Assumes the bench steers it with plain levels on the fast clock.
`timescale 1ns/1ps
module pscc_analog_model (
  input  wire       clk_i,
  input  wire       charge_enable_i,
  input  wire       attach_i,
  input  wire       cur_on_i,
  input  wire       hot_i,
  input  wire       key_long_i,
  output reg        lf_clk_o,
  output wire       src_present_o,
  output wire       src_absent_o,
  output wire       overheat_o,
  output wire       cur_tenth_o,
  output wire       cur_low_o,
  output wire       cur_flow_o,
  output wire [1:0] phase_o,
  output wire [2:0] band_o,
  output wire       long_press_o
);
  // ==========================================================
  // Slow clock: free running, one period per eight fast cycles
  reg [1:0] div_q;  // Fast-cycle divider
  initial div_q = 2'h0;
  initial lf_clk_o = 1'b0;
  always @(posedge clk_i) begin
    div_q <= div_q + 2'h1;
    if (div_q == 2'h3) lf_clk_o <= ~lf_clk_o;
  end

  // ==========================================================
  // Comparators: the two source conditions are exclusive levels
  assign src_present_o = attach_i;
  assign src_absent_o  = ~attach_i;
  // Current flows only while the charger is enabled, with no ramp wait
  assign cur_flow_o    = charge_enable_i & cur_on_i;
  assign cur_tenth_o   = cur_flow_o;
  assign cur_low_o     = ~cur_flow_o;
  // Phase is nonzero even when cool, so masking in the status is visible
  assign phase_o       = cur_flow_o ? 2'h2 : 2'h1;
  assign band_o        = cur_flow_o ? 3'h4 : 3'h0;
  assign overheat_o    = hot_i;
  assign long_press_o  = key_long_i;
endmodule

//--- pscc_top_test.sv
// Self-checking bench for the supply and charger control block.
// Assumes a 40 MHz clock and shortened debounce and qualify counts.
`timescale 1ns/1ps
module pscc_top_test;
  // ==========================================================
  // Stimulus, observation and bookkeeping
  reg        clk = 1'b0;
  reg        srst = 1'b1;
  reg        sel = 1'b0, wr = 1'b0;  // Register strobe and direction
  reg  [7:0] addr = 8'h00, wdata = 8'h00;
  reg        deb_short = 1'b0, bat_low = 1'b0;
  reg        attach = 1'b0, cur_on = 1'b0, hot = 1'b0, key_long = 1'b0;
  wire [7:0] rdata;
  wire [2:0] io, core, bd;
  wire [3:0] cur;
  wire [1:0] thr, ph;
  wire       fine, en, tenth, rate, main, lf, sp, sa, oh, ct, cl, cf, lp;
  integer    n_errors = 0, n_checks = 0, cyc = 0, i;
  reg  [7:0] d;
  reg  [19:0] lvl = 20'hAAA95;  // Battery, temperature and wire readings

  always #12.5 clk = ~clk;

  pscc_top #(.DEB_LONG_CYC(32'd20), .DEB_SHORT_CYC(32'd8), .CHG_QUAL_CYC(32'd50)) u_dut (
    .clk_i(clk), .srst_i(srst), .reg_sel_i(sel), .reg_wr_i(wr), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_rdata_o(rdata), .deb_short_i(deb_short), .lf_clk_i(lf),
    .src_present_i(sp), .src_absent_i(sa), .bat_low_i(bat_low), .overheat_i(oh),
    .cur_tenth_i(ct), .cur_low_i(cl), .cur_flow_i(cf), .phase_i(ph), .band_i(bd),
    .long_press_i(lp), .bat_level_i(lvl[19:13]), .temp_level_i(lvl[12:6]),
    .wire_level_i(lvl[5:0]),
    .io_supply_level_o(io), .core_supply_level_o(core), .core_supply_fine_o(fine),
    .charge_enable_o(en), .charge_current_o(cur), .charge_tenth_o(tenth),
    .overheat_threshold_sel_o(thr), .monitor_rate_sel_o(rate), .main_supply_enable_o(main));

  pscc_analog_model u_ana (.clk_i(clk), .charge_enable_i(en), .attach_i(attach),
    .cur_on_i(cur_on), .hot_i(hot), .key_long_i(key_long), .lf_clk_o(lf),
    .src_present_o(sp), .src_absent_o(sa), .overheat_o(oh), .cur_tenth_o(ct),
    .cur_low_o(cl), .cur_flow_o(cf), .phase_o(ph), .band_o(bd), .long_press_o(lp));

  // ==========================================================
  // Register access and comparison tasks
  task chk(input [7:0] got, input [7:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // One-cycle write strobe, released after the taking edge
  task wrt(input [7:0] a, input [7:0] v);
    begin
      @(posedge clk);
      {sel, wr, addr, wdata} <= {2'b11, a, v};
      @(posedge clk);
      sel <= 1'b0;
    end
  endtask
  // Read data is settled just after the taking edge
  task rcm(input [7:0] a, input [7:0] m, input [7:0] exp);
    begin
      @(posedge clk);
      {sel, wr, addr} <= {2'b10, a};
      @(posedge clk);
      sel <= 1'b0;
      #1;
      d = rdata;
      chk(d & m, exp);
    end
  endtask

  // ==========================================================
  // Scenarios
  task t_reset;
    begin
      rcm(8'h90, 8'hFF, 8'h58);
      rcm(8'h92, 8'hFF, 8'h00);
      rcm(8'h94, 8'hFF, 8'h05);
      rcm(8'h95, 8'hFF, 8'h40);
      rcm(8'h97, 8'hFF, 8'h6F);
      rcm(8'h9B, 8'hFF, 8'hC0);
      rcm(8'h9C, 8'hFF, 8'h55);
      rcm(8'h9D, 8'hFF, 8'h2A);
      rcm(8'h9E, 8'hFF, 8'h15);
      rcm(8'hA4, 8'hFF, 8'h40);
      rcm(8'hA7, 8'hFF, 8'h67);
      rcm(8'hA9, 8'hFF, 8'h20);
      wrt(8'h95, 8'hFF);
      rcm(8'h95, 8'hFF, 8'h40);
      rcm(8'h80, 8'hFF, 8'h00);
      lvl <= ~lvl;
      repeat (2) @(posedge clk);
      rcm(8'h9E, 8'hFF, 8'h2A);
      $display("t_reset done");
    end
  endtask
  // Every level code; core gets the inverse of the I/O code
  task t_volt;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        wrt(8'h90, {i[1], i[2:0], ~i[2:0], i[0]});
        @(posedge clk);
        #1;
        chk({1'b0, io, core, fine}, {1'b0, i[2:0], ~i[2:0], i[0]});
        rcm(8'h90, 8'hFF, {i[1], i[2:0], ~i[2:0], i[0]});
      end
      wrt(8'h90, 8'h58);
      $display("t_volt done");
    end
  endtask
  // Supply domain for the charger is taken as already on
  task t_charge;
    begin
      for (i = 0; i < 12; i = i + 1) begin
        wrt(8'h94, 8'h20 | i[7:0]);
        @(posedge clk);
        #1;
        chk({3'h0, en, cur}, {4'h1, i[3:0]});
      end
      cur_on <= 1'b1;
      repeat (40) @(posedge clk);
      rcm(8'h95, 8'h41, 8'h00);
      repeat (30) @(posedge clk);
      rcm(8'h95, 8'h41, 8'h01);
      cur_on <= 1'b0;
      repeat (5) @(posedge clk);
      rcm(8'h95, 8'h41, 8'h40);
      wrt(8'h94, 8'h3B);
      bat_low <= 1'b1;
      repeat (6) @(posedge clk);
      chk({7'h0, tenth}, 8'h01);
      wrt(8'h94, 8'h2B);
      repeat (4) @(posedge clk);
      chk({7'h0, tenth}, 8'h00);
      bat_low <= 1'b0;
      cur_on <= 1'b1;
      hot <= 1'b1;
      rcm(8'h95, 8'h80, 8'h00);
      repeat (6) @(posedge clk);
      rcm(8'h95, 8'hFF, 8'hA8);
      hot <= 1'b0;
      repeat (6) @(posedge clk);
      rcm(8'h95, 8'hFF, 8'h08);
      cur_on <= 1'b0;
      wrt(8'h97, 8'h5F);
      wrt(8'h9B, 8'h40);
      wrt(8'h94, 8'h05);
      chk({5'h0, thr, rate}, 8'h02);
      $display("t_charge done");
    end
  endtask
  task t_source;
    begin
      for (i = 0; i < 2; i = i + 1) begin
        deb_short <= i[0];
        attach <= 1'b1;
        repeat (i ? 2 : 12) @(posedge clk);
        rcm(8'h94, 8'h80, 8'h00);
        repeat (i ? 10 : 20) @(posedge clk);
        rcm(8'h94, 8'h80, 8'h80);
        attach <= 1'b0;
        repeat (i ? 2 : 12) @(posedge clk);
        rcm(8'h94, 8'h80, 8'h80);
        repeat (i ? 10 : 20) @(posedge clk);
        rcm(8'h94, 8'h80, 8'h00);
      end
      deb_short <= 1'b0;
      $display("t_source done");
    end
  endtask
  // Long press is read and released before the supply is turned off
  task t_aon;
    begin
      key_long <= 1'b1;
      repeat (4) @(posedge clk);
      wrt(8'hA9, 8'h00);
      rcm(8'hA9, 8'h78, 8'h40);
      key_long <= 1'b0;
      repeat (4) @(posedge clk);
      rcm(8'hA9, 8'h40, 8'h00);
      wrt(8'hA7, 8'h66);
      rcm(8'hA7, 8'hFF, 8'h67);
      repeat (50) @(posedge clk);
      rcm(8'hA7, 8'hFF, 8'h66);
      chk({7'h0, main}, 8'h00);
      wrt(8'hA7, 8'h67);
      repeat (10) @(posedge clk);
      wrt(8'hA7, 8'h65);
      repeat (20) @(posedge clk);
      rcm(8'hA7, 8'hFF, 8'h66);
      repeat (50) @(posedge clk);
      rcm(8'hA7, 8'hFF, 8'h65);
      chk({7'h0, main}, 8'h01);
      $display("t_aon done");
    end
  endtask

  // ==========================================================
  // Verdict, hang guard and main sequence
  task results;
    begin
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  // Whole run needs about 500 cycles; the guard allows ample margin
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      n_errors = n_errors + 1;
      results;
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    t_reset;
    t_volt;
    t_charge;
    t_source;
    t_aon;
    results;
  end
endmodule
